/* rtl/tams_pkg.sv */
// Purpose: Shared constants for the thermal alarm mask and status block
// Assumes: 25 MHz system clock, 8-bit command codes and register data
// Notes: Channel bit positions 0..5 are remote 1..6, position 6 is local
`default_nettype none
package tams_pkg;
    // ========================================================
    // Command codes
    localparam logic [7:0] CMD_CONFIG1 = 8'h41;
    localparam logic [7:0] CMD_WARN_MASK = 8'h42;
    localparam logic [7:0] CMD_OT_MASK = 8'h43;
    localparam logic [7:0] CMD_WARN_STATUS = 8'h44;
    localparam logic [7:0] CMD_OT_STATUS = 8'h45;
    localparam logic [7:0] CMD_FAULT_STATUS = 8'h46;
    // ========================================================
    // Field layouts and reset values
    localparam int CFG1_RC_BIT = 3;
    localparam int CFG1_SOFT_RESET_BIT = 6;
    localparam logic [7:0] WARN_MASK_BITS = 8'h7F;
    localparam logic [7:0] OT_MASK_BITS = 8'h39;
    localparam logic [6:0] OT_CAPABLE = 7'h39;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int NUM_CH = 7;
    localparam int NUM_REMOTE = 6;
    localparam int TEMP_W = 8;
    localparam logic [2:0] LOCAL_BIT = 3'h6;
    localparam logic [2:0] LOCAL_CODE = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [8:0] HYST_DEG = 9'h004;
    // ========================================================
    // Timing
    localparam int SYS_CLK_HZ = 25000000;
    localparam int RC_EXTRA_MS = 125;
    localparam int RC_EXTRA_CYCLES = RC_EXTRA_MS * (SYS_CLK_HZ / 1000);
    // ========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        SEQ_PICK = 4'h1,
        SEQ_CONV = 4'h2,
        SEQ_EXTEND = 4'h4,
        SEQ_EVAL = 4'h8
    } tams_seq_type;
endpackage
`default_nettype wire

/* rtl/tams_result_cdc.sv */
// Purpose: Carries one word from the converter clock into the system clock
// Assumes: Source holds nothing; the word is captured on valid and ready
// Notes: Toggle handshake, one word in flight, ready drops until acknowledged
`default_nettype none
module tams_result_cdc
    import tams_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Source side, converter clock
    input wire logic src_clk,
    input wire logic src_valid,
    input wire logic [WIDTH-1:0] src_data,
    output logic src_ready,
    // Destination side, system clock
    input wire logic dst_clk,
    input wire logic dst_reset,
    input wire logic dst_ce,
    output logic dst_valid,
    output logic [WIDTH-1:0] dst_data
);
    logic rst_s1, rst_s2;
    logic req_tgl, busy;
    logic [WIDTH-1:0] hold;
    logic ack_s1, ack_s2;
    logic req_s1, req_s2, ack_tgl;

    // ========================================================
    // Source domain
    always_ff @(posedge src_clk)
    begin
        rst_s1 <= dst_reset;
        rst_s2 <= rst_s1;
        ack_s1 <= ack_tgl;
        ack_s2 <= ack_s1;
    end

    assign src_ready = !busy && !rst_s2;

    always_ff @(posedge src_clk)
    begin
        if (rst_s2)
        begin
            req_tgl <= 1'b0;
            busy <= 1'b0;
            hold <= '0;
        end
        else if (src_valid && src_ready)
        begin
            hold <= src_data;
            req_tgl <= !req_tgl;
            busy <= 1'b1;
        end
        else if (busy && ack_s2 == req_tgl)
        begin
            busy <= 1'b0;
        end
    end

    // ========================================================
    // Destination domain; hold is stable while the toggle is pending
    always_ff @(posedge dst_clk)
    begin
        if (dst_reset)
        begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            ack_tgl <= 1'b0;
            dst_valid <= 1'b0;
            dst_data <= '0;
        end
        else if (dst_ce)
        begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            dst_valid <= (req_s2 != ack_tgl);
            if (req_s2 != ack_tgl)
            begin
                ack_tgl <= req_s2;
                dst_data <= hold;
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/tams_alarm.sv */
// Purpose: Alarm compare, status, masking and channel sequencing of a
//          seven channel temperature monitor
// Assumes: Limits arrive as inputs; results arrive on the converter clock
// Notes: Pins are open drain, low when asserted
// Overview of operation
// - Warning mask bit 6 blocks the local channel from the warning pin.
// - Warning mask bits 0-5 block remote channels 1-6; bit 7 reserved.
// - Overtemp mask bits 0,3,4,5 block remote 1,4,5,6; other bits reserved.
// - Warning status bit 6 sets when local result exceeds its warning limit.
// - Warning status bits 0-5 set when remote 1-6 exceed warning limits.
// - Cleared warning status reasserts at next conversion end if still over.
// - Reading overtemp status clears its bits even with condition present.
// - Reading overtemp status leaves the overtemp pin unchanged.
// - Fault ends only when temperature drops 4 degrees below its limit.
// - Configuration 1 bit 3 enables resistance cancellation on remote 1.
// - Cancellation lengthens remote 1 conversion by 125 ms.
// - Open or supply-tied diode flags a fault and is skipped.
// - Masked channels never assert either pin, whatever their status.
// - Overtemp status bits 0,3,4,5 set when remote 1,4,5,6 exceed limits.
// - Fault status bits 1-6 report diode faults on remote 1-6.
// - Masks read/write at codes 42, 43; status read-only at 44-46.
`default_nettype none
module tams_alarm
    import tams_pkg::*;
#(
    parameter int EXTEND_CYCLES = RC_EXTRA_CYCLES
)
(
    // System clock and control
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sys_ce,
    // Converter result link
    input wire logic adc_clk,
    input wire logic adc_result_valid,
    input wire logic [TEMP_W-1:0] adc_result_temp,
    output logic adc_result_ready,
    // Conversion request to the converter
    output logic conv_request,
    output logic [2:0] conv_channel,
    output logic conv_extended,
    // Diode fault sense pins
    input wire logic [NUM_REMOTE-1:0] diode_anode_in,
    input wire logic [NUM_REMOTE-1:0] diode_cathode_in,
    // Limits, eight bits per channel
    input wire logic [NUM_CH*TEMP_W-1:0] warn_limit_in,
    input wire logic [4*TEMP_W-1:0] ot_limit_in,
    // Register port
    input wire logic [7:0] reg_cmd,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Alarm pins
    output logic warning_alert_n_out,
    output logic warning_alert_n_oe,
    output logic overtemp_shutdown_n_out,
    output logic overtemp_shutdown_n_oe
);
    logic [7:0] warning_mask_config;
    logic [7:0] overtemp_mask_config;
    logic [7:0] warning_status;
    logic [7:0] overtemp_status;
    logic [7:0] fault_status;
    logic rc_enable;
    logic soft_reset;
    logic rd_warn, rd_ot;
    logic [NUM_REMOTE-1:0] anode_s1, anode_s2, cathode_s1, cathode_s2;
    logic [NUM_REMOTE-1:0] diode_fault;
    logic res_valid;
    logic [TEMP_W-1:0] res_temp;
    logic res_take;
    logic [TEMP_W-1:0] held_temp;
    tams_seq_type state;
    logic [2:0] cur_bit;
    logic [2:0] next_bit;
    localparam int CW = $clog2(EXTEND_CYCLES + 1);
    localparam logic [CW-1:0] EXT_LOAD = CW'(EXTEND_CYCLES - 1);
    logic [CW-1:0] ext_count;
    logic eval;
    logic [NUM_CH-1:0] warn_active, ot_active;
    logic [NUM_CH-1:0] warn_set, ot_set;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // ========================================================
    // Register port
    assign soft_reset = reg_write && reg_cmd == CMD_CONFIG1 && reg_wdata[CFG1_SOFT_RESET_BIT];
    assign rd_warn = reg_read && reg_cmd == CMD_WARN_STATUS;
    assign rd_ot = reg_read && reg_cmd == CMD_OT_STATUS;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            warning_mask_config <= REG_RESET;
            overtemp_mask_config <= REG_RESET;
            rc_enable <= 1'b0;
        end
        else if (sys_ce)
        begin
            if (soft_reset)
            begin
                warning_mask_config <= REG_RESET;
                overtemp_mask_config <= REG_RESET;
                rc_enable <= 1'b0;
            end
            else if (reg_write)
            begin
                case (reg_cmd)
                    CMD_CONFIG1: rc_enable <= reg_wdata[CFG1_RC_BIT];
                    CMD_WARN_MASK: warning_mask_config <= reg_wdata & WARN_MASK_BITS;
                    CMD_OT_MASK: overtemp_mask_config <= reg_wdata & OT_MASK_BITS;
                    default: ;
                endcase
            end
        end
    end

    // Status codes are read-only; writes to them are dropped
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            reg_rdata <= REG_RESET;
            reg_rvalid <= 1'b0;
        end
        else if (sys_ce)
        begin
            reg_rvalid <= reg_read;
            if (reg_read)
            begin
                case (reg_cmd)
                    CMD_CONFIG1: reg_rdata <= {4'h0, rc_enable, 3'h0};
                    CMD_WARN_MASK: reg_rdata <= warning_mask_config;
                    CMD_OT_MASK: reg_rdata <= overtemp_mask_config;
                    CMD_WARN_STATUS: reg_rdata <= warning_status;
                    CMD_OT_STATUS: reg_rdata <= overtemp_status;
                    CMD_FAULT_STATUS: reg_rdata <= fault_status;
                    default: reg_rdata <= REG_RESET;
                endcase
            end
        end
    end

    // ========================================================
    // Diode fault sense, two flops per pin
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            anode_s1 <= '0;
            anode_s2 <= '0;
            cathode_s1 <= '0;
            cathode_s2 <= '0;
        end
        else if (sys_ce)
        begin
            anode_s1 <= diode_anode_in;
            anode_s2 <= anode_s1;
            cathode_s1 <= diode_cathode_in;
            cathode_s2 <= cathode_s1;
        end
    end

    // Anode or cathode high covers both the open pair and the tied case
    assign diode_fault = anode_s2 | cathode_s2;

    // ========================================================
    // Result crossing from the converter clock
    tams_result_cdc #(
        .WIDTH(TEMP_W)
    ) u_result_cdc (
        .src_clk(adc_clk),
        .src_valid(adc_result_valid),
        .src_data(adc_result_temp),
        .src_ready(adc_result_ready),
        .dst_clk(sys_clk),
        .dst_reset(reset),
        .dst_ce(sys_ce),
        .dst_valid(res_valid),
        .dst_data(res_temp)
    );

    // Results outside a requested conversion are stale and dropped
    assign res_take = res_valid && sys_ce && state == SEQ_CONV;
    assign next_bit = (cur_bit == LOCAL_BIT) ? FIRST_BIT : cur_bit + 3'h1;
    assign eval = sys_ce && state == SEQ_EVAL;

    // ========================================================
    // Channel sequencer
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state <= SEQ_PICK;
            cur_bit <= FIRST_BIT;
            conv_request <= 1'b0;
            conv_channel <= 3'h0;
            conv_extended <= 1'b0;
            ext_count <= '0;
            held_temp <= '0;
        end
        else if (sys_ce)
        begin
            if (soft_reset)
            begin
                state <= SEQ_PICK;
                cur_bit <= FIRST_BIT;
                conv_request <= 1'b0;
                conv_extended <= 1'b0;
            end
            else
            begin
                case (state)
                    SEQ_PICK:
                    begin
                        if (cur_bit != LOCAL_BIT && diode_fault[cur_bit])
                        begin
                            cur_bit <= next_bit;
                        end
                        else
                        begin
                            conv_request <= 1'b1;
                            conv_channel <= (cur_bit == LOCAL_BIT) ? LOCAL_CODE
                                                                   : cur_bit + 3'h1;
                            conv_extended <= rc_enable && cur_bit == FIRST_BIT;
                            state <= SEQ_CONV;
                        end
                    end
                    SEQ_CONV:
                    begin
                        if (res_valid)
                        begin
                            held_temp <= res_temp;
                            if (conv_extended)
                            begin
                                ext_count <= EXT_LOAD;
                                state <= SEQ_EXTEND;
                            end
                            else
                            begin
                                conv_request <= 1'b0;
                                state <= SEQ_EVAL;
                            end
                        end
                    end
                    SEQ_EXTEND:
                    begin
                        // The conversion ends only after the added time
                        if (ext_count == '0)
                        begin
                            conv_request <= 1'b0;
                            state <= SEQ_EVAL;
                        end
                        else
                        begin
                            ext_count <= ext_count - 1'b1;
                        end
                    end
                    SEQ_EVAL:
                    begin
                        cur_bit <= next_bit;
                        state <= SEQ_PICK;
                    end
                    default: state <= SEQ_PICK;
                endcase
            end
        end
    end

    // ========================================================
    // Per-channel compare with hysteresis
    genvar b;
    generate
        for (b = 0; b < NUM_CH; b++)
        begin : g_ch
            logic [TEMP_W-1:0] wlim;
            logic w_over, w_clear, w_me;
            assign wlim = warn_limit_in[b*TEMP_W +: TEMP_W];
            assign w_me = eval && cur_bit == 3'(b);
            assign w_over = held_temp > wlim;
            // Clear covers both a cooler reading and a raised limit
            assign w_clear = ({1'b0, held_temp} + HYST_DEG) <= {1'b0, wlim};
            assign warn_set[b] = w_me && (w_over || (warn_active[b] && !w_clear));

            always_ff @(posedge sys_clk)
            begin
                if (reset)
                begin
                    warn_active[b] <= 1'b0;
                end
                else if (sys_ce)
                begin
                    if (soft_reset)
                        warn_active[b] <= 1'b0;
                    else if (w_me)
                        warn_active[b] <= w_over || (warn_active[b] && !w_clear);
                end
            end

            if (OT_CAPABLE[b])
            begin : g_ot
                localparam int SLOT = (b == 0) ? 0 : b - 2;
                logic [TEMP_W-1:0] olim;
                logic o_over, o_clear;
                assign olim = ot_limit_in[SLOT*TEMP_W +: TEMP_W];
                assign o_over = held_temp > olim;
                assign o_clear = ({1'b0, held_temp} + HYST_DEG) <= {1'b0, olim};
                assign ot_set[b] = w_me && (o_over || (ot_active[b] && !o_clear));

                always_ff @(posedge sys_clk)
                begin
                    if (reset)
                    begin
                        ot_active[b] <= 1'b0;
                    end
                    else if (sys_ce)
                    begin
                        if (soft_reset)
                            ot_active[b] <= 1'b0;
                        else if (w_me)
                            ot_active[b] <= o_over || (ot_active[b] && !o_clear);
                    end
                end
            end
            else
            begin : g_no_ot
                assign ot_set[b] = 1'b0;
                assign ot_active[b] = 1'b0;
            end

            a_hyst_holds: assert property (
                w_me && !soft_reset && warn_active[b] && !w_over && !w_clear |=> warn_active[b])
                else $error("warning condition ended inside hysteresis band");
        end
    endgenerate

    // ========================================================
    // Status registers; a new set wins over a read clear
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            warning_status <= REG_RESET;
            overtemp_status <= REG_RESET;
            fault_status <= REG_RESET;
        end
        else if (sys_ce)
        begin
            if (soft_reset)
            begin
                warning_status <= REG_RESET;
                overtemp_status <= REG_RESET;
                fault_status <= REG_RESET;
            end
            else
            begin
                warning_status <= {1'b0, (warning_status[6:0] & ~{7{rd_warn}})
                                   | warn_set};
                overtemp_status <= {1'b0, (overtemp_status[6:0] & ~{7{rd_ot}})
                                    | ot_set};
                fault_status <= {1'b0, diode_fault, 1'b0};
            end
        end
    end

    // ========================================================
    // Alarm pins; only ever pulled low
    // Overtemp pin follows the condition, not the status, so a read keeps it
    assign warning_alert_n_out = 1'b0;
    assign overtemp_shutdown_n_out = 1'b0;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            warning_alert_n_oe <= 1'b0;
            overtemp_shutdown_n_oe <= 1'b0;
        end
        else if (sys_ce)
        begin
            warning_alert_n_oe <= |(warning_status[6:0] & ~warning_mask_config[6:0]);
            overtemp_shutdown_n_oe <= |(ot_active & ~overtemp_mask_config[6:0]);
        end
    end

    // ========================================================
    // Checks
    a_local_masked: assert property (
        sys_ce && warning_mask_config[6] && warning_status[6]
        && (warning_status[5:0] & ~warning_mask_config[5:0]) == 6'h00 |=> !warning_alert_n_oe)
        else $error("masked local warning drove the pin");
    a_remote_unmasked: assert property (
        sys_ce && (warning_status[5:0] & ~warning_mask_config[5:0]) != 6'h00
        |=> warning_alert_n_oe)
        else $error("unmasked remote warning did not drive the pin");
    a_ot_masked: assert property (
        sys_ce && (ot_active & ~overtemp_mask_config[6:0]) == 7'h00 |=> !overtemp_shutdown_n_oe)
        else $error("masked overtemp channel drove the pin");
    a_warn_sets: assert property (
        eval && cur_bit == LOCAL_BIT && held_temp > warn_limit_in[6*TEMP_W +: TEMP_W]
        && !soft_reset |=> warning_status[6])
        else $error("local warning status not set");
    a_ot_read_clears: assert property (
        sys_ce && rd_ot && !soft_reset && ot_set == 7'h00 |=> overtemp_status == 8'h00)
        else $error("overtemp status survived a read");
    a_ot_pin_kept: assert property (
        sys_ce && rd_ot && overtemp_shutdown_n_oe && !soft_reset && !eval
        && (ot_active & ~overtemp_mask_config[6:0]) != 7'h00 |=> overtemp_shutdown_n_oe)
        else $error("overtemp pin released by a status read");
    a_extend_load: assert property (
        res_take && conv_extended && !soft_reset |=> state == SEQ_EXTEND && ext_count == EXT_LOAD)
        else $error("extended conversion not started with full count");
    a_fault_skip: assert property (
        sys_ce && state == SEQ_PICK && cur_bit != LOCAL_BIT && diode_fault[cur_bit]
        |=> state == SEQ_PICK && !conv_request)
        else $error("faulted channel was converted");
    a_soft_clear: assert property (
        sys_ce && soft_reset |=> warning_mask_config == 8'h00 && warning_status == 8'h00)
        else $error("software reset left mask or status set");
endmodule
`default_nettype wire

/* verif/tams_conv_model.sv */
// Purpose: Converter stand-in on the link clock for the alarm block
// Assumes: conv_request is a level from the system clock domain
// Notes: Answers after a random delay; temp shows junk when not valid
`default_nettype none
module tams_conv_model
(
    // Link side
    input wire logic adc_clk,
    input wire logic conv_request,
    input wire logic [2:0] conv_channel,
    input wire logic [55:0] temps,
    input wire logic adc_result_ready,
    output logic adc_result_valid = 1'b0,
    output logic [7:0] adc_result_temp = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] sync = 2'h0;
    logic done = 1'b0;
    logic [2:0] dly = 3'h0;
    // ========================================
    // Request is foreign to this clock, so it is synchronised first
    always @(posedge adc_clk)
    begin
        sync <= {sync[0], conv_request};
        if (adc_result_valid && adc_result_ready)
        begin
            adc_result_valid <= 1'b0;
            adc_result_temp <= ~adc_result_temp;
            done <= 1'b1;
        end
        else if (!adc_result_valid && sync[1] && !done)
        begin
            if (dly == 3'h0)
            begin
                adc_result_valid <= 1'b1;
                adc_result_temp <= temps[8*(conv_channel-1) +: 8];
                dly <= 3'($urandom % 8);
            end
            else
                dly <= dly - 3'h1;
        end
        if (!sync[1])
            done <= 1'b0;
    end
endmodule
`default_nettype wire

/* verif/test_thermal_alarm_mask_status.sv */
// Purpose: Self-checking bench for the alarm mask and status block
// Assumes: Limits static, warning 0x50 on every channel, overtemp 0x60 on remote 1,4,5,6
// Notes: Extension shortened to EXT cycles; rounds wait for two local ends
`default_nettype none
module test_thermal_alarm_mask_status;
    import tams_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EXT = 20;
    logic sys_clk = 0, adc_clk = 0, reset = 1, sys_ce = 1, reg_write = 0, reg_read = 0;
    logic adc_result_valid, adc_result_ready, conv_request, conv_extended, reg_rvalid;
    logic warning_alert_n_out, warning_alert_n_oe, overtemp_shutdown_n_out;
    logic overtemp_shutdown_n_oe, req_q = 0, ch_bad = 0, rc = 0;
    logic [7:0] reg_cmd = 0, reg_wdata = 0, reg_rdata, adc_result_temp, v, m;
    logic [2:0] conv_channel, lch = 0;
    logic [5:0] diode_anode_in = 0, diode_cathode_in = 0;
    logic [55:0] temps = 0, warn_limit_in = {7{8'h50}};
    logic [31:0] ot_limit_in = {4{8'h60}};
    int err_total = 0, samples_checked = 0, loc_done = 0, len = 0, len1 = 0, a;
    tams_alarm #(.EXTEND_CYCLES(EXT)) tams_alarm_i (.sys_clk, .reset, .sys_ce, .adc_clk,
        .adc_result_valid, .adc_result_temp, .adc_result_ready, .conv_request,
        .conv_channel, .conv_extended, .diode_anode_in, .diode_cathode_in,
        .warn_limit_in, .ot_limit_in, .reg_cmd, .reg_write, .reg_wdata, .reg_read,
        .reg_rdata, .reg_rvalid, .warning_alert_n_out, .warning_alert_n_oe,
        .overtemp_shutdown_n_out, .overtemp_shutdown_n_oe);
    tams_conv_model tams_conv_model_i (.adc_clk, .conv_request, .conv_channel, .temps,
        .adc_result_ready, .adc_result_valid, .adc_result_temp);
    initial forever #20 sys_clk = ~sys_clk;
    initial begin #7; forever #15 adc_clk = ~adc_clk; end
    // ========================================
    // Conversion monitor: lengths, completions, skipped or wrongly extended channels
    always @(posedge sys_clk)
    begin
        req_q <= conv_request;
        len <= conv_request ? len + 1 : 0;
        if (conv_request)
            lch <= conv_channel;
        if (req_q && !conv_request && lch == 3'h7)
            loc_done <= loc_done + 1;
        if (req_q && !conv_request && lch == 3'h1)
            len1 <= len;
        if (conv_request && ({1'b0, diode_anode_in | diode_cathode_in} >> (conv_channel - 1)) & 1)
            ch_bad <= 1;
        if (conv_request && conv_extended && (conv_channel != 3'h1 || !rc))
            ch_bad <= 1;
    end
    // ========================================
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task wreg(input logic [7:0] c, input logic [7:0] d);
        @(negedge sys_clk);
        reg_cmd = c; reg_wdata = d; reg_write = 1;
        @(negedge sys_clk);
        reg_write = 0;
    endtask
    task rchk(input logic [7:0] c, input logic [7:0] e);
        @(negedge sys_clk);
        reg_cmd = c; reg_read = 1;
        @(negedge sys_clk);
        reg_read = 0;
        chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
        chk($sformatf("reg %h", c), reg_rdata, e);
    endtask
    task round;
        int t;
        t = loc_done;
        for (int i = 0; i < 20000 && loc_done < t + 2; i++) @(posedge sys_clk);
        chk("round", {7'h00, loc_done >= t + 2}, 8'h01);
        @(negedge sys_clk);
    endtask
    task pins(input logic w, input logic o);
        chk("warn pin", {7'h00, warning_alert_n_oe}, {7'h00, w});
        chk("ot pin", {7'h00, overtemp_shutdown_n_oe}, {7'h00, o});
        chk("pin level", {6'h00, warning_alert_n_out, overtemp_shutdown_n_out}, 8'h00);
    endtask
    task conclude;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin #2ms; err_total++; conclude; end
    // ========================================
    initial
    begin
        v = $urandom(32'h7585f4f2);
        repeat (4) @(negedge sys_clk);
        reset = 0;
        for (int c = 8'h42; c <= 8'h46; c++) rchk(8'(c), 8'h00);
        wreg(8'h42, 8'hFF); rchk(8'h42, 8'h7F);
        wreg(8'h43, 8'hFF); rchk(8'h43, 8'h39);
        wreg(8'h44, 8'hFF); wreg(8'h42, 8'h00); wreg(8'h43, 8'h00);
        rchk(8'h44, 8'h00); rchk(8'h47, 8'h00);
        // Over every limit only now, so the reads after reset still see clear status
        for (int k = 0; k < 7; k++) temps[8*k +: 8] = 8'h61 + 8'($urandom % 16);
        round; pins(1, 1);
        rchk(8'h44, 8'h7F);
        rchk(8'h45, 8'h39);
        // Remote 1 cannot be evaluated again this soon, so only the reads have acted
        @(negedge sys_clk);
        pins(0, 1);
        round; rchk(8'h44, 8'h7F);
        round;
        for (int i = 0; i < 5; i++)
        begin
            m = (i == 0) ? 8'hFF : 8'($urandom);
            wreg(8'h42, m); wreg(8'h43, m);
            repeat (3) @(negedge sys_clk);
            pins(|(8'h7F & ~m), |(8'h39 & ~m));
        end
        wreg(8'h42, 8'h00); wreg(8'h43, 8'h00);
        temps = {7{8'h5E}}; round; pins(1, 1);
        temps = {7{8'h5C}}; round; pins(1, 0);
        temps = {7{8'h40}}; round;
        // A read while the clock enable is low must neither answer nor clear
        @(negedge sys_clk);
        sys_ce = 0; reg_cmd = 8'h44; reg_read = 1;
        repeat (2) @(negedge sys_clk);
        reg_read = 0;
        chk("frozen rvalid", {7'h00, reg_rvalid}, 8'h00);
        sys_ce = 1;
        rchk(8'h44, 8'h7F); round;
        rchk(8'h44, 8'h00); pins(0, 0);
        diode_anode_in = 6'($urandom); diode_cathode_in = 6'($urandom) & 6'h0C;
        m = {2'h0, diode_anode_in | diode_cathode_in};
        wreg(8'h42, m); wreg(8'h43, m & 8'h39);
        round; rchk(8'h46, {m[6:0], 1'b0});
        ch_bad = 0; round; chk("skip", {7'h00, ch_bad}, 8'h00);
        diode_anode_in = 0; diode_cathode_in = 0;
        round; round; a = len1;
        wreg(8'h41, 8'h08); rc = 1; rchk(8'h41, 8'h08);
        round; round;
        chk("ext len", {7'h00, len1 >= a + EXT - 10 && len1 <= a + EXT + 10}, 8'h01);
        chk("ext ch", {7'h00, ch_bad}, 8'h00);
        wreg(8'h41, 8'h40); rc = 0;
        rchk(8'h42, 8'h00); rchk(8'h43, 8'h00); rchk(8'h41, 8'h00);
        conclude;
    end
endmodule
`default_nettype wire
